// >>> hw/seg_word_mem.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Segment word store with registered read data
module seg_word_mem
    import tx_ingress_pkg::*;
(
    // Clock
    input  wire logic              clk_i,
    // Write port
    input  wire logic              wr_en_i,
    input  wire logic [AW-1:0]     wr_addr_i,
    input  wire logic [WORD_W-1:0] wr_data_i,
    // Read port
    input  wire logic              rd_en_i,
    input  wire logic [AW-1:0]     rd_addr_i,
    output logic      [WORD_W-1:0] rd_data_o
);

    logic [WORD_W-1:0] mem_ff [DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i) begin
            rd_data_o <= mem_ff[rd_addr_i];
        end
    end

endmodule

`default_nettype wire

// >>> hw/tx_ingress_pkg.sv
// ==========================================================
// Shared constants and types
package tx_ingress_pkg;

    // ==========================================================
    // Segment geometry and buffering
    localparam int SEG_N  = 4;
    localparam int SEG_W  = 128;
    localparam int DEPTH  = 8;
    localparam int AW     = 3;
    localparam int PTR_W  = 4;
    localparam logic [PTR_W-1:0] FILL_FULL        = 4'h8;
    localparam logic [PTR_W-1:0] FILL_READY_LIMIT = 4'h5;

    // ==========================================================
    // Line slot pacing
    localparam int DIV_W = 2;
    localparam logic [DIV_W-1:0] DIV_LAST = 2'h3;

    // Error code control word pattern
    localparam logic [SEG_W-1:0] ERROR_CODE_WORD = {16{8'hFE}};

    // ==========================================================
    // Register map
    localparam int PADDR_W = 8;
    localparam logic [PADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [PADDR_W-1:0] OFS_MASK   = 8'h08;
    localparam logic [PADDR_W-1:0] OFS_LEVEL  = 8'h0C;
    localparam int CTRL_TX_RESET = 0;
    localparam int CTRL_DRAIN_EN = 1;
    localparam int EVT_OVF       = 0;
    localparam int EVT_UNF       = 1;
    localparam int EVT_W         = 2;
    localparam int LVL_FILL_LSB  = 0;
    localparam int LVL_IN_PKT    = 4;
    localparam int LVL_READY     = 5;
    localparam int LVL_OVF       = 6;
    localparam int LVL_UNF       = 7;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [SEG_W-1:0] data;
        logic             sop;
        logic             eop;
        logic             bad;
    } seg_s;

    typedef seg_s [SEG_N-1:0] word_t;

    typedef struct packed {
        word_t            segs;
        logic [SEG_N-1:0] fcs_off;
        logic             err_block;
    } line_word_s;

    localparam int WORD_W = $bits(word_t);

endpackage

// >>> hw/tx_segmented_packet_ingress.sv
`timescale 1ns/100ps
`default_nettype none

module tx_segmented_packet_ingress
    import tx_ingress_pkg::*;
(
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Local packet bus, user side
    input  wire logic [SEG_N-1:0][SEG_W-1:0]   transmit_segment_data_i,
    input  wire logic [SEG_N-1:0]              transmit_segment_enable_i,
    input  wire logic [SEG_N-1:0]              transmit_segment_packet_start_i,
    input  wire logic [SEG_N-1:0]              transmit_segment_packet_end_i,
    input  wire logic [SEG_N-1:0]              transmit_segment_packet_bad_i,
    output logic                               transmit_ready_o,
    output logic                               transmit_overflow_o,
    output logic                               transmit_underflow_o,
    // Line side
    output line_word_s                         line_word_o,
    output logic                               line_valid_o,
    // APB slave
    input  wire logic [PADDR_W-1:0]            paddr_i,
    input  wire logic                          psel_i,
    input  wire logic                          penable_i,
    input  wire logic                          pwrite_i,
    input  wire logic [31:0]                   pwdata_i,
    output logic      [31:0]                   prdata_o,
    output logic                               pready_o,
    output logic                               pslverr_o,
    // Interrupt
    output logic                               irq_o
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic             ovf;
        logic             unf;
        logic             in_pkt;
        logic             corrupt;
        logic             rd_pend;
        logic             drain_en;
        logic [DIV_W-1:0] div;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic [31:0]      prdata;
        logic             line_valid;
        line_word_s       line;
    } state_s;

    state_s            st_ff;
    state_s            nxt_st;

    // ==========================================================
    // Datapath and strobes
    word_t             wr_word;
    word_t             rd_word;
    logic [WORD_W-1:0] rd_raw;
    logic [PTR_W-1:0]  fill;
    logic              full;
    logic              empty;
    logic              push;
    logic              wr_en;
    logic              tick;
    logic              pop;
    logic              ovf_evt;
    logic              unf_evt;
    logic              apb_wr;
    logic              apb_setup;
    logic              flush;
    logic              wr_ctrl;
    logic              wr_status;
    logic              wr_mask;

    // ==========================================================
    // Address decode
    function automatic logic addr_hit(input logic [PADDR_W-1:0] a);
        addr_hit = (a == OFS_CTRL) || (a == OFS_STATUS) ||
                   (a == OFS_MASK) || (a == OFS_LEVEL);
    endfunction

    function automatic logic [31:0] reg_read(input logic [PADDR_W-1:0] a,
                                             input state_s           s,
                                             input logic [PTR_W-1:0] f,
                                             input logic             rdy);
        reg_read = 32'h0000_0000;
        case (a)
            OFS_CTRL: begin
                reg_read[CTRL_DRAIN_EN] = s.drain_en;
            end
            OFS_STATUS: begin
                reg_read[EVT_W-1:0] = s.status;
            end
            OFS_MASK: begin
                reg_read[EVT_W-1:0] = s.mask;
            end
            OFS_LEVEL: begin
                reg_read[LVL_FILL_LSB +: PTR_W] = f;
                reg_read[LVL_IN_PKT]            = s.in_pkt;
                reg_read[LVL_READY]             = rdy;
                reg_read[LVL_OVF]               = s.ovf;
                reg_read[LVL_UNF]               = s.unf;
            end
            default: begin
                reg_read = 32'h0000_0000;
            end
        endcase
    endfunction

    // ==========================================================
    // Reset state
    function automatic state_s reset_state();
        reset_state          = '0;
        reset_state.drain_en = 1'b1;
    endfunction

    // ==========================================================
    // Segment capture
    for (genvar g = 0; g < SEG_N; g++) begin : g_seg
        always_comb begin
            wr_word[g].data = '0;
            wr_word[g].sop  = 1'b0;
            wr_word[g].eop  = 1'b0;
            wr_word[g].bad  = 1'b0;
            if (transmit_segment_enable_i[g]) begin
                wr_word[g].data = transmit_segment_data_i[g];
                wr_word[g].sop  = transmit_segment_packet_start_i[g];
                wr_word[g].eop  = transmit_segment_packet_end_i[g];
                wr_word[g].bad  = transmit_segment_packet_bad_i[g] &
                                  transmit_segment_packet_end_i[g];
            end
        end
    end

    assign rd_word = word_t'(rd_raw);

    // ==========================================================
    // Buffer
    seg_word_mem u_mem (
        .clk_i     (clk_i),
        .wr_en_i   (wr_en),
        .wr_addr_i (st_ff.wr_ptr[AW-1:0]),
        .wr_data_i (WORD_W'(wr_word)),
        .rd_en_i   (pop),
        .rd_addr_i (st_ff.rd_ptr[AW-1:0]),
        .rd_data_o (rd_raw)
    );

    // ==========================================================
    // Register write strobes
    assign apb_setup = psel_i & ~penable_i;
    assign apb_wr    = psel_i & penable_i & pwrite_i & addr_hit(paddr_i);
    assign wr_ctrl   = apb_wr & (paddr_i == OFS_CTRL);
    assign wr_status = apb_wr & (paddr_i == OFS_STATUS);
    assign wr_mask   = apb_wr & (paddr_i == OFS_MASK);
    assign flush     = wr_ctrl & pwdata_i[CTRL_TX_RESET];

    // ==========================================================
    // Flow control
    assign fill      = st_ff.wr_ptr - st_ff.rd_ptr;
    assign full      = (fill == FILL_FULL);
    assign empty     = (fill == '0);
    assign push      = |transmit_segment_enable_i;
    assign wr_en     = push & ~full & ~flush;
    assign ovf_evt   = push & full & ~flush;

    // ==========================================================
    // Line slot pacing
    assign tick      = (st_ff.div == '0) & st_ff.drain_en & ~st_ff.rd_pend;
    assign pop       = tick & ~empty & ~flush;
    assign unf_evt   = tick & empty & st_ff.in_pkt & ~st_ff.unf & ~flush;

    // ==========================================================
    // Next state
    always_comb begin
        logic pkt;
        logic bad_run;
        pkt     = 1'b0;
        bad_run = 1'b0;
        nxt_st  = st_ff;

        nxt_st.line_valid = 1'b0;
        nxt_st.rd_pend    = pop;
        nxt_st.div        = (st_ff.div == DIV_LAST) ? '0 : st_ff.div + 1'b1;

        if (wr_en) begin
            nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
        end
        if (ovf_evt) begin
            nxt_st.ovf = 1'b1;
        end

        if (pop) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
            nxt_st.unf    = 1'b0;
        end else if (tick && empty && st_ff.in_pkt) begin
            nxt_st.unf            = 1'b1;
            nxt_st.corrupt        = 1'b1;
            nxt_st.line           = '0;
            nxt_st.line.err_block = 1'b1;
            nxt_st.line_valid     = 1'b1;
        end

        if (st_ff.rd_pend) begin
            pkt                   = st_ff.in_pkt;
            bad_run               = st_ff.corrupt;
            nxt_st.line.err_block = 1'b0;
            for (int i = 0; i < SEG_N; i++) begin
                nxt_st.line.segs[i]    = rd_word[i];
                nxt_st.line.fcs_off[i] = 1'b0;
                if (rd_word[i].sop) begin
                    pkt     = 1'b1;
                    bad_run = 1'b0;
                end
                if (rd_word[i].eop) begin
                    if (rd_word[i].bad || bad_run) begin
                        nxt_st.line.segs[i].data = ERROR_CODE_WORD;
                        nxt_st.line.segs[i].bad  = 1'b1;
                        nxt_st.line.fcs_off[i]   = 1'b1;
                    end
                    pkt     = 1'b0;
                    bad_run = 1'b0;
                end
            end
            nxt_st.in_pkt     = pkt;
            nxt_st.corrupt    = bad_run;
            nxt_st.line_valid = 1'b1;
        end

        if (flush) begin
            nxt_st.wr_ptr     = '0;
            nxt_st.rd_ptr     = '0;
            nxt_st.ovf        = 1'b0;
            nxt_st.unf        = 1'b0;
            nxt_st.in_pkt     = 1'b0;
            nxt_st.corrupt    = 1'b0;
            nxt_st.rd_pend    = 1'b0;
            nxt_st.line_valid = 1'b0;
        end

        if (wr_ctrl) begin
            nxt_st.drain_en = pwdata_i[CTRL_DRAIN_EN];
        end
        if (wr_mask) begin
            nxt_st.mask = pwdata_i[EVT_W-1:0];
        end
        if (wr_status) begin
            nxt_st.status = st_ff.status & ~pwdata_i[EVT_W-1:0];
        end
        nxt_st.status[EVT_OVF] = nxt_st.status[EVT_OVF] | ovf_evt;
        nxt_st.status[EVT_UNF] = nxt_st.status[EVT_UNF] | unf_evt;

        if (apb_setup) begin
            nxt_st.prdata = reg_read(paddr_i, st_ff, fill, transmit_ready_o);
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= reset_state();
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    assign transmit_ready_o     = (fill < FILL_READY_LIMIT);
    assign transmit_overflow_o  = st_ff.ovf;
    assign transmit_underflow_o = st_ff.unf;
    assign line_word_o          = st_ff.line;
    assign line_valid_o         = st_ff.line_valid;

    // ==========================================================
    // Register bus and interrupt
    assign prdata_o             = st_ff.prdata;
    assign pready_o             = 1'b1;
    assign pslverr_o            = psel_i & penable_i & ~addr_hit(paddr_i);
    assign irq_o                = |(st_ff.status & st_ff.mask);

endmodule

`default_nettype wire

// >>> test/pkt_source.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// User packet source
module pkt_source
    import tx_ingress_pkg::*;
(
    // Control
    input  wire logic                  clk_i,
    input  wire logic                  rdy_i,
    input  wire logic                  go_i,
    input  wire logic [7:0]            words_i,
    input  wire logic                  bad_i,
    input  wire logic                  push_i,
    input  wire logic                  stall_i,
    // Segment bus
    output logic [SEG_N-1:0][SEG_W-1:0] data_o,
    output logic [SEG_N-1:0]           en_o,
    output logic [SEG_N-1:0]           sop_o,
    output logic [SEG_N-1:0]           eop_o,
    output logic [SEG_N-1:0]           bad_o,
    output logic                       busy_o
);
    logic [7:0] left_ff = 8'h00;
    logic [7:0] wc_ff   = 8'h00;
    initial {data_o, en_o, sop_o, eop_o, bad_o} = '0;
    assign busy_o = left_ff != 8'h00;
    always @(posedge clk_i) begin
        if (go_i) begin
            left_ff <= words_i;
            wc_ff <= 8'h00;
        end
        if (busy_o && (rdy_i || push_i) && !stall_i) begin
            en_o <= 4'hF;
            for (int s = 0; s < SEG_N; s++) begin
                data_o[s] <= {112'h0, wc_ff, 8'(s)};
            end
            sop_o <= {3'h0, wc_ff == 8'h00};
            eop_o <= {left_ff == 8'h01, 3'h0};
            bad_o <= {bad_i && left_ff == 8'h01, 3'h0};
            left_ff <= left_ff - 8'h01;
            wc_ff <= wc_ff + 8'h01;
        end else begin
            en_o <= 4'h0;
            {data_o, sop_o, eop_o, bad_o} <= ~{data_o, sop_o, eop_o, bad_o};
        end
    end
endmodule
`default_nettype wire

// >>> test/tx_ingress_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Port checker
module tx_ingress_asserts
    import tx_ingress_pkg::*;
(
    // Watched ports
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [SEG_N-1:0]   transmit_segment_enable_i,
    input  wire logic               transmit_ready_o,
    input  wire logic               transmit_overflow_o,
    input  wire logic               transmit_underflow_o,
    input  wire line_word_s         line_word_o,
    input  wire logic               line_valid_o,
    input  wire logic [PADDR_W-1:0] paddr_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [31:0]        pwdata_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic tx_rst = psel_i && penable_i && pwrite_i && paddr_i == OFS_CTRL
                        && pwdata_i[CTRL_TX_RESET];
    wire logic breach = |transmit_segment_enable_i && !transmit_ready_o;
    logic      txr_d_ff;
    wire logic recent = tx_rst || txr_d_ff;
    always_ff @(posedge clk_i) begin
        txr_d_ff <= rst_i ? 1'h0 : tx_rst;
    end
    sequence err_out;
        line_valid_o && line_word_o.err_block;
    endsequence
    AST_OVF_CAUSE: assert property ($rose(transmit_overflow_o) |-> $past(breach))
        else $error("overflow without breach");
    AST_OVF_STICKY: assert property (transmit_overflow_o && !recent
        |=> transmit_overflow_o) else $error("overflow dropped");
    AST_TXRST_CLEAR: assert property (tx_rst |-> ##[1:2] !transmit_overflow_o
        && !transmit_underflow_o) else $error("tx reset left flags");
    AST_RST_IDLE: assert property ($fell(rst_i) |-> transmit_ready_o
        && !transmit_overflow_o && !transmit_underflow_o) else $error("bad idle state");
    AST_READY_RISE: assert property ($rose(transmit_ready_o) && !$past(recent)
        |-> ##[0:3] line_valid_o) else $error("ready rose without drain");
    AST_ERR_BLOCK: assert property (err_out |-> transmit_underflow_o
        && line_word_o.segs == '0) else $error("error block malformed");
    AST_UNF_LINE: assert property ($rose(transmit_underflow_o) |-> ##[0:4] err_out)
        else $error("underflow without error block");
    for (genvar i = 0; i < SEG_N; i++) begin : g_seg
        AST_BAD_WORD: assert property (line_valid_o && line_word_o.segs[i].eop
            && line_word_o.segs[i].bad |-> line_word_o.segs[i].data == ERROR_CODE_WORD
            && line_word_o.fcs_off[i]) else $error("bad end word not replaced");
    end
endmodule
bind tx_segmented_packet_ingress tx_ingress_asserts u_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .transmit_segment_enable_i(transmit_segment_enable_i), .transmit_ready_o(transmit_ready_o),
    .transmit_overflow_o(transmit_overflow_o), .transmit_underflow_o(transmit_underflow_o),
    .line_word_o(line_word_o), .line_valid_o(line_valid_o), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i));
`default_nettype wire

// >>> test/tx_segmented_packet_ingress_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Testbench
module tx_segmented_packet_ingress_tb
    import tx_ingress_pkg::*;
;
    logic                        clk_i = 1'h0;
    logic                        rst_i = 1'h1;
    logic [SEG_N-1:0][SEG_W-1:0] sd;
    logic [SEG_N-1:0]            sen, ssop, seop, sbad;
    logic                        rdy, ovf, unf, lvalid, irq, pready, perr, busy, rerr;
    logic [31:0]                 prdata, rdata;
    line_word_s                  lword, last_w;
    logic [127:0]                exp_d;
    logic [7:0]                  paddr = 8'h00, words = 8'h00, exp_wc = 8'h00;
    logic [31:0]                 pwdata = 32'h0;
    logic                        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic                        go = 1'h0, bad = 1'h0, push = 1'h0, stall = 1'h0;
    int                          n_mismatch = 0, n_compared = 0, n_good = 0, n_err = 0, goal = 0;
    always #25 clk_i = ~clk_i;
    tx_segmented_packet_ingress dut (.clk_i(clk_i), .rst_i(rst_i),
        .transmit_segment_data_i(sd), .transmit_segment_enable_i(sen),
        .transmit_segment_packet_start_i(ssop), .transmit_segment_packet_end_i(seop),
        .transmit_segment_packet_bad_i(sbad), .transmit_ready_o(rdy), .transmit_overflow_o(ovf),
        .transmit_underflow_o(unf), .line_word_o(lword), .line_valid_o(lvalid),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .irq_o(irq));
    pkt_source src (.clk_i(clk_i), .rdy_i(rdy), .go_i(go), .words_i(words), .bad_i(bad),
        .push_i(push), .stall_i(stall), .data_o(sd), .en_o(sen), .sop_o(ssop), .eop_o(seop),
        .bad_o(sbad), .busy_o(busy));
    // ====================
    // Tasks
    task automatic results();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'h1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (pready === 1'h1) break;
        end
        if (k == 20) begin
            n_mismatch++;
            results();
        end
        rdata = prdata;
        rerr = perr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check("register", rdata, e);
    endtask
    task automatic send(input logic [7:0] n, input logic b, input logic p);
        @(posedge clk_i);
        go <= 1'h1;
        words <= n;
        bad <= b;
        push <= p;
        goal += int'(n);
        @(posedge clk_i);
        go <= 1'h0;
    endtask
    function automatic logic hit(input int k);
        case (k)
            0: return !rdy;
            1: return unf;
            2: return !busy;
            default: return n_good >= goal;
        endcase
    endfunction
    task automatic wait_on(input int k);
        @(negedge clk_i);
        for (int i = 0; i < 500 && hit(k) !== 1'h1; i++) @(negedge clk_i);
        if (hit(k) !== 1'h1) begin
            n_mismatch++;
            results();
        end
    endtask
    // ====================
    // Line monitor
    always @(negedge clk_i) begin
        if (lvalid === 1'h1) begin
            last_w = lword;
            if (lword.err_block === 1'h1) begin
                n_err++;
            end else begin
                if (lword.segs[0].sop === 1'h1) exp_wc = 8'h00;
                for (int s = 0; s < SEG_N; s++) begin
                    if (lword.segs[s].bad !== 1'h1) begin
                        exp_d = {112'h0, exp_wc, 8'(s)};
                        check("data", lword.segs[s].data, exp_d);
                    end
                end
                exp_wc++;
                n_good++;
            end
        end
    end
    // ====================
    // Scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        @(negedge clk_i);
        check("ready", rdy, 1'h1);
        check("overflow", ovf, 1'h0);
        check("underflow", unf, 1'h0);
        check("irq", irq, 1'h0);
        rd_chk(OFS_CTRL, 32'h2);
        rd_chk(OFS_MASK, 32'h0);
        rd_chk(OFS_LEVEL, 32'h20);
        rd_chk(8'h10, 32'h0);
        check("slave error", rerr, 1'h1);
        send(8'h2, 1'h1, 1'h0);
        wait_on(3);
        check("error word", last_w.segs[3].data, ERROR_CODE_WORD);
        check("fcs off", last_w.fcs_off, 4'h8);
        send(8'h3, 1'h0, 1'h0);
        wait_on(3);
        check("fcs on", last_w.fcs_off, 4'h0);
        check("end flag", last_w.segs[3].eop, 1'h1);
        apb(1'h1, OFS_CTRL, 32'h0);
        send(8'hC, 1'h0, 1'h0);
        wait_on(0);
        rd_chk(OFS_STATUS, 32'h0);
        apb(1'h1, OFS_CTRL, 32'h2);
        wait_on(3);
        check("no overflow", ovf, 1'h0);
        send(8'h6, 1'h0, 1'h0);
        @(posedge clk_i);
        stall <= 1'h1;
        wait_on(1);
        rd_chk(OFS_STATUS, 32'h2);
        rd_chk(OFS_LEVEL, 32'hB0);
        check("error blocks", n_err > 0, 1'h1);
        @(posedge clk_i);
        stall <= 1'h0;
        wait_on(3);
        check("corrupt end", last_w.segs[3].data, ERROR_CODE_WORD);
        check("underflow", unf, 1'h0);
        apb(1'h1, OFS_STATUS, 32'h3);
        apb(1'h1, OFS_CTRL, 32'h0);
        send(8'hA, 1'h0, 1'h1);
        wait_on(2);
        @(negedge clk_i);
        check("overflow", ovf, 1'h1);
        check("ready", rdy, 1'h0);
        check("irq", irq, 1'h0);
        rd_chk(OFS_STATUS, 32'h1);
        rd_chk(OFS_LEVEL, 32'h48);
        apb(1'h1, OFS_MASK, 32'h1);
        @(negedge clk_i);
        check("irq", irq, 1'h1);
        apb(1'h1, OFS_STATUS, 32'h1);
        @(negedge clk_i);
        check("irq", irq, 1'h0);
        check("overflow", ovf, 1'h1);
        apb(1'h1, OFS_CTRL, 32'h3);
        repeat (2) @(negedge clk_i);
        check("overflow", ovf, 1'h0);
        check("ready", rdy, 1'h1);
        results();
    end
endmodule
`default_nettype wire
